/* File: bench/cpwm_pin_model.sv */
// Far-side pin model for the capture and PWM unit
`timescale 1ns/1ps
`default_nettype none
module cpwm_pin_model (
	input  wire logic unit_pin_out,
	input  wire logic unit_pin_oe,
	input  wire logic ext_en,
	input  wire logic ext_lvl,
	output logic      unit_pin_in
);
	// Unit wins while driving, else the outside source, else the pull-up
	assign unit_pin_in = unit_pin_oe ? unit_pin_out : (ext_en ? ext_lvl : 1'b1);
endmodule
`default_nettype wire

/* File: bench/cpwm_properties.sv */
// Port assertions for the capture and PWM unit
`timescale 1ns/1ps
`default_nettype none
module cpwm_properties
	import cpwm_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [2:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        irq,
	input wire logic [7:0]  period_count,
	input wire logic [1:0]  phase_bits,
	input wire logic        unit_pin_out,
	input wire logic        unit_pin_oe
);
	logic [6:0]  ctl_q;
	logic [15:0] duty_q;
	wire         wr = write && !waitrequest;
	wire         pp = ctl_q[2:0] == CPWM_MODE_PWM && !ctl_q[CPWM_CTL_DIR];
	wire         lvl = {period_count, phase_bits} < (ctl_q[CPWM_CTL_ALIGN] ? duty_q[15:6] : duty_q[9:0]);
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_q <= CPWM_CTL_RESET;
			duty_q <= CPWM_DUTY_RESET;
		end else if (wr && address == CPWM_REG_CONTROL)
			ctl_q <= writedata[6:0];
		else if (wr && address == CPWM_REG_DUTY)
			duty_q <= writedata[15:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_req; (read || write) && waitrequest; endsequence
	AST_WAIT:
		assert property (s_req |=> !waitrequest) else $error("no answer");
	AST_RELEASE:
		assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
	AST_UNMAP:
		assert property (read && address > CPWM_REG_STATE && !waitrequest |-> readdata == 0) else $error("unmapped");
	AST_PWM:
		assert property ($past(pp && !ctl_q[6]) |-> unit_pin_oe && unit_pin_out == $past(lvl)) else $error("pwm");
	AST_ODRAIN:
		assert property ($past(pp && ctl_q[6]) |-> !unit_pin_out && unit_pin_oe == !$past(lvl)) else $error("drain");
	AST_IDLE:
		assert property ($past(!pp) |-> !unit_pin_oe && !unit_pin_out) else $error("pin driven");
	AST_FLAG:
		assert property ($fell(irq) |-> $past(write) || $past(write, 2)) else $error("flag lost");
	AST_MASKOFF:
		assert property (wr && address == CPWM_REG_MASK && !writedata[0] |-> ##2 !irq) else $error("irq masked");
endmodule
bind cpwm_capture_pwm_unit cpwm_properties PROPS (.mclk, .rst, .address, .read, .write, .writedata, .readdata,
	.waitrequest, .irq, .period_count, .phase_bits, .unit_pin_out, .unit_pin_oe);
`default_nettype wire

/* File: bench/test_capture_pwm_unit.sv */
// Self-checking bench for the capture and PWM unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s %h %h", n, e, g); end end
module test_capture_pwm_unit
	import cpwm_pkg::*;
;
	logic        mclk = 0, rst = 1, read = 0, write = 0, ext_en = 1, ext_lvl = 0;
	logic        unit_pin_in, unit_pin_out, unit_pin_oe, waitrequest, irq;
	logic [2:0]  address = '0;
	logic [31:0] writedata = '0, readdata, q;
	logic [15:0] timebase_count = '0;
	logic [7:0]  period_count = '0;
	logic [1:0]  phase_bits = '0;
	int          n_errors = 0, checks_done = 0;
	logic [7:0]  period_limit = '0;
	logic        timer_run = 0;
	logic [1:0]  e;
	logic [31:0] ctl_w, duty_w;
	cpwm_capture_pwm_unit DUT (.mclk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .irq,
		.timebase_count, .period_count, .phase_bits, .unit_pin_in, .unit_pin_out, .unit_pin_oe);
	cpwm_pin_model PIN (.unit_pin_out, .unit_pin_oe, .ext_en, .ext_lvl, .unit_pin_in);
	initial forever #25 mclk = ~mclk;
	// Period timer on the instruction clock: the phase bits step every clock
	always @(posedge mclk) begin
		if (timer_run) begin
			phase_bits <= phase_bits + 2'h1;
			if (phase_bits == 2'h3)
				period_count <= (period_count == period_limit) ? 8'h00 : period_count + 8'h01;
		end
	end
	task automatic give_verdict;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= d;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 0;
		write <= 0;
	endtask
	task automatic pin(input logic v);
		ext_lvl <= v;
		repeat (4) @(posedge mclk);
	endtask
	function automatic int need(input int m);
		return m == CPWM_MODE_RISE4 ? 4 : m == CPWM_MODE_RISE16 ? 16 : 1;
	endfunction
	// Expected {oe, out}: high while the time base is below the duty, open-drain only pulls low
	function automatic logic [1:0] pwm_exp(input logic [9:0] t, input logic [15:0] d, input logic [6:0] c);
		logic lv;
		lv = t < (c[CPWM_CTL_ALIGN] ? d[CPWM_LEFT_LSB +: 10] : d[9:0]);
		return c[CPWM_CTL_ODRAIN] ? {~lv, 1'b0} : {1'b1, lv};
	endfunction
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		give_verdict;
	end
	initial begin
		void'($urandom(41819));
		repeat (8) @(posedge mclk);
		rst <= 0;
		bus(0, CPWM_REG_CONTROL, 0);
		`CHK("ctl", 32'(CPWM_CTL_RESET), q)
		bus(0, 3'h7, 0);
		`CHK("unmapped", 32'h0000_0000, q)
		bus(1, CPWM_REG_MASK, 1);
		for (int m = 1; m <= 5; m++) begin
			bus(1, CPWM_REG_CONTROL, 32'(m) | 32'h0000_0020);
			bus(1, CPWM_REG_FLAGS, 1);
			timebase_count <= 16'($urandom);
			for (int k = 1; k <= need(m); k++) begin
				pin(1);
				bus(0, CPWM_REG_FLAGS, 0);
				`CHK("flag", 32'(m == 2 || m == 5 || (m != 1 && k == need(m))), q)
				pin(0);
			end
			bus(0, CPWM_REG_CAPTURE, 0);
			`CHK("capture", {16'h0000, timebase_count}, q)
			`CHK("irq", 1'b1, irq)
		end
		timebase_count <= 16'($urandom);
		pin(1);
		repeat (40) @(posedge mclk);
		bus(0, CPWM_REG_CAPTURE, 0);
		`CHK("overwrite", {16'h0000, timebase_count}, q)
		`CHK("sticky", 1'b1, irq)
		bus(1, CPWM_REG_MASK, 0);
		@(negedge mclk);
		`CHK("masked", 1'b0, irq)
		bus(1, CPWM_REG_MASK, 1);
		@(negedge mclk);
		`CHK("unmasked", 1'b1, irq)
		bus(1, CPWM_REG_FLAGS, 1);
		bus(0, CPWM_REG_FLAGS, 0);
		`CHK("cleared", 32'h0000_0000, q)
		ext_en <= 0;
		for (int i = 0; i < 6; i++) begin
			ctl_w = 32'h0000_0026 | ($urandom & 32'h0000_0050);
			duty_w = $urandom;
			period_limit <= 8'($urandom);
			bus(1, CPWM_REG_CONTROL, ctl_w);
			bus(1, CPWM_REG_DUTY, duty_w);
			timer_run <= 1;
			bus(1, CPWM_REG_CONTROL, ctl_w & ~32'h0000_0020);
			repeat (150) begin
				@(negedge mclk);
				e = pwm_exp({period_count, phase_bits}, duty_w[15:0], ctl_w[6:0]);
				@(negedge mclk);
				`CHK("pwm", e, {unit_pin_oe, unit_pin_out})
			end
		end
		bus(1, CPWM_REG_CONTROL, 32'h0000_0026);
		repeat (2) @(negedge mclk);
		`CHK("oe", 1'b0, unit_pin_oe)
		`CHK("out", 1'b0, unit_pin_out)
		@(posedge mclk);
		rst <= 1;
		repeat (2) @(posedge mclk);
		rst <= 0;
		bus(0, CPWM_REG_CONTROL, 0);
		`CHK("ctl after reset", 32'(CPWM_CTL_RESET), q)
		bus(0, CPWM_REG_MASK, 0);
		`CHK("mask after reset", 32'h0000_0000, q)
		give_verdict;
	end
endmodule
`default_nettype wire

/* File: rtl/cpwm_capture_pwm_unit.sv */
// Capture and PWM unit with an Avalon-MM register slave
// Notes on behaviour
// - Each qualifying capture event copies the full 16-bit timer count into the capture hold register.
// - The mode selects falling, rising, every 4th rising, every 16th rising or every edge as the event.
// - Every capture sets the capture event flag in the peripheral flag register.
// - The capture event flag stays set until software clears it and hardware never clears it.
// - A new capture simply overwrites the held value with no overrun indication.
// - In PWM mode the 8-bit period count is extended by two low bits to a 10-bit time base.
// - The 10-bit duty value in the 16-bit compare register is left or right aligned by the format bit.
// - The PWM waveform is driven onto the pin only while the direction bit is cleared.
// - In PWM output mode a control bit makes the pin driver open-drain.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cpwm_capture_pwm_unit
	import cpwm_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [2:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             irq,
	input  wire logic [15:0] timebase_count,
	input  wire logic [7:0]  period_count,
	input  wire logic [1:0]  phase_bits,
	input  wire logic        unit_pin_in,
	output logic             unit_pin_out,
	output logic             unit_pin_oe
);
	// Bus handshake
	logic        wait_q;
	logic        wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        access;
	logic        wr_now;

	// Registers
	logic [6:0]  ctl_q;
	logic [6:0]  ctl_d;
	logic [15:0] duty_q;
	logic [15:0] duty_d;
	logic [15:0] hold_q;
	logic [15:0] hold_d;
	logic        flag_q;
	logic        flag_d;
	logic        mask_q;
	logic        mask_d;
	logic        irq_q;
	logic        irq_d;

	// Pin sampling and edge counting
	logic        sync1_q;
	logic        sync2_q;
	logic        prev_q;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [2:0]  mode_prev_q;
	logic        event_now;
	logic [1:0]  fill_q;
	logic [1:0]  fill_d;
	logic        primed;

	// PWM output
	logic        pout_q;
	logic        pout_d;
	logic        poe_q;
	logic        poe_d;

	cpwm_mode_t  mode;
	logic        rise;
	logic        fall;
	logic [9:0]  tbase;
	logic [9:0]  duty10;
	logic        level;

	function automatic logic [31:0] cpwm_read_mux(
		input logic [2:0]  idx,
		input logic [6:0]  ctl,
		input logic [15:0] hold,
		input logic [15:0] duty,
		input logic        flag,
		input logic        mask,
		input logic [3:0]  cnt,
		input logic        pin
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (idx)
			CPWM_REG_CONTROL: r = {25'h000_0000, ctl};
			CPWM_REG_CAPTURE: r = {16'h0000, hold};
			CPWM_REG_DUTY:    r = {16'h0000, duty};
			CPWM_REG_FLAGS:   r = {31'h0000_0000, flag};
			CPWM_REG_MASK:    r = {31'h0000_0000, mask};
			CPWM_REG_STATE:   r = {27'h000_0000, pin, cnt};
			default:          r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Write strobe for one register index
	function automatic logic cpwm_wr_hit(
		input logic       wr,
		input logic [2:0] addr,
		input logic [2:0] idx
	);
		return wr && (addr == idx);
	endfunction

	assign mode   = cpwm_mode_t'(ctl_q[CPWM_CTL_MODE_LSB +: CPWM_CTL_MODE_W]);
	assign access = read | write;
	assign wr_now = write & ~wait_q;
	// Edges count only once the synchroniser holds real pin samples
	assign primed = (fill_q == 2'h3);
	assign fill_d = primed ? fill_q : fill_q + 2'h1;
	assign rise   = primed & sync2_q & ~prev_q;
	assign fall   = primed & ~sync2_q & prev_q;

	// PWM time base and duty compare
	assign tbase  = {period_count, phase_bits};
	assign duty10 = ctl_q[CPWM_CTL_ALIGN] ? duty_q[CPWM_LEFT_LSB +: 10] : duty_q[9:0];
	assign level  = tbase < duty10;

	// Bus slave: one wait cycle, then the transfer completes
	always_comb begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if (access && wait_q) begin
			wait_d  = 1'b0;
			rdata_d = cpwm_read_mux(address, ctl_q, hold_q, duty_q, flag_q, mask_q, cnt_q, sync2_q);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Edge qualification
	always_comb begin
		cnt_d     = cnt_q;
		event_now = 1'b0;
		if (mode != cpwm_mode_t'(mode_prev_q)) begin
			cnt_d = 4'h0;
		end else begin
			case (mode)
				CPWM_MODE_FALL:   event_now = fall;
				CPWM_MODE_RISE:   event_now = rise;
				CPWM_MODE_BOTH:   event_now = rise | fall;
				CPWM_MODE_RISE4: begin
					if (rise) begin
						event_now = (cnt_q == CPWM_DIV4_LAST);
						cnt_d     = event_now ? 4'h0 : cnt_q + 4'h1;
					end
				end
				CPWM_MODE_RISE16: begin
					if (rise) begin
						event_now = (cnt_q == CPWM_DIV16_LAST);
						cnt_d     = event_now ? 4'h0 : cnt_q + 4'h1;
					end
				end
				default:          event_now = 1'b0;
			endcase
		end
	end

	// Two-stage pin synchroniser, edge history and fill count
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			fill_q  <= 2'h0;
		end else begin
			sync1_q <= unit_pin_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			fill_q  <= fill_d;
		end
	end

	// Edge counter and mode history
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q       <= 4'h0;
			mode_prev_q <= CPWM_MODE_OFF;
		end else begin
			cnt_q       <= cnt_d;
			mode_prev_q <= mode;
		end
	end

	// Control and duty registers
	always_comb begin
		ctl_d  = ctl_q;
		duty_d = duty_q;
		if (cpwm_wr_hit(wr_now, address, CPWM_REG_CONTROL)) begin
			ctl_d = writedata[6:0];
		end
		if (cpwm_wr_hit(wr_now, address, CPWM_REG_DUTY)) begin
			duty_d = writedata[15:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_q  <= CPWM_CTL_RESET;
			duty_q <= CPWM_DUTY_RESET;
		end else begin
			ctl_q  <= ctl_d;
			duty_q <= duty_d;
		end
	end

	// Capture hold register, a later event simply overwrites it
	always_comb begin
		hold_d = hold_q;
		if (event_now) begin
			hold_d = timebase_count;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_q <= 16'h0000;
		end else begin
			hold_q <= hold_d;
		end
	end

	// Sticky flag, mask and level interrupt; a set in the clearing cycle wins
	always_comb begin
		flag_d = flag_q;
		mask_d = mask_q;
		if (cpwm_wr_hit(wr_now, address, CPWM_REG_FLAGS)) begin
			flag_d = flag_q & ~writedata[CPWM_FLAG_CAPTURE];
		end
		if (cpwm_wr_hit(wr_now, address, CPWM_REG_MASK)) begin
			mask_d = writedata[CPWM_FLAG_CAPTURE];
		end
		if (event_now) begin
			flag_d = 1'b1;
		end
		irq_d = flag_d & mask_d;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			flag_q <= 1'b0;
			mask_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			flag_q <= flag_d;
			mask_q <= mask_d;
			irq_q  <= irq_d;
		end
	end

	// Pin driver
	always_comb begin
		pout_d = 1'b0;
		poe_d  = 1'b0;
		if (mode == CPWM_MODE_PWM && !ctl_q[CPWM_CTL_DIR]) begin
			if (ctl_q[CPWM_CTL_ODRAIN]) begin
				pout_d = 1'b0;
				poe_d  = ~level;
			end else begin
				pout_d = level;
				poe_d  = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pout_q <= 1'b0;
			poe_q  <= 1'b0;
		end else begin
			pout_q <= pout_d;
			poe_q  <= poe_d;
		end
	end

	assign readdata     = rdata_q;
	assign waitrequest  = wait_q;
	assign irq          = irq_q;
	assign unit_pin_out = pout_q;
	assign unit_pin_oe  = poe_q;
endmodule
`default_nettype wire

/* File: rtl/cpwm_pkg.sv */
// Constants and types for the capture and PWM unit
package cpwm_pkg;
	// Register word indices on the Avalon-MM address
	localparam logic [2:0] CPWM_REG_CONTROL = 3'h0;
	localparam logic [2:0] CPWM_REG_CAPTURE = 3'h1;
	localparam logic [2:0] CPWM_REG_DUTY    = 3'h2;
	localparam logic [2:0] CPWM_REG_FLAGS   = 3'h3;
	localparam logic [2:0] CPWM_REG_MASK    = 3'h4;
	localparam logic [2:0] CPWM_REG_STATE   = 3'h5;

	// Control register fields
	localparam int CPWM_CTL_MODE_LSB = 0;
	localparam int CPWM_CTL_MODE_W   = 3;
	localparam int CPWM_CTL_ALIGN    = 4;
	localparam int CPWM_CTL_DIR      = 5;
	localparam int CPWM_CTL_ODRAIN   = 6;

	// Reset values
	localparam logic [6:0]  CPWM_CTL_RESET  = 7'h20;
	localparam logic [15:0] CPWM_DUTY_RESET = 16'h0000;

	// Flag register bit
	localparam int CPWM_FLAG_CAPTURE = 0;

	// Edge prescale terminal counts
	localparam logic [3:0] CPWM_DIV4_LAST  = 4'h3;
	localparam logic [3:0] CPWM_DIV16_LAST = 4'hf;

	// Left aligned duty occupies the top ten bits
	localparam int CPWM_LEFT_LSB = 6;

	typedef enum logic [2:0] {
		CPWM_MODE_OFF    = 3'b000,
		CPWM_MODE_FALL   = 3'b001,
		CPWM_MODE_RISE   = 3'b010,
		CPWM_MODE_RISE4  = 3'b011,
		CPWM_MODE_RISE16 = 3'b100,
		CPWM_MODE_BOTH   = 3'b101,
		CPWM_MODE_PWM    = 3'b110
	} cpwm_mode_t;
endpackage
